// file: dlc_pkg.sv
// package with constants, types and helpers for the delay-locked clock manager
// Contract
// - reset drops lock within four source cycles
// - reset is active high, dynamic or low
// - reset zeroes taps; outputs may misbehave
// - assert reset only on reconfigure or retune
// - locked doubled output is 2x, 50/50
// - unlocked doubled output is 1x, 25/75
// - high-frequency variant has no doubled output
// - divided output uses static ratio from list
// - unconfigured divide ratio defaults to two
// - divided output always has 50/50 duty
// - standard variant adds 90/180/270 phase outputs
// - high-frequency variant adds only 180 phase
// - duty correction on gives 50/50 1x outputs
// - duty correction off copies source duty
// - lock indicated only after lock achieved
// - consumers ignore outputs until lock asserted
// - startup wait holds config-complete until lock
// - feedback only from phase-0 or doubled output
// - off-chip pad feedback must use doubled output
// - simple wrapper exposes input and deskewed output
// - source period change requires a reset pulse
// - clock stop: outputs run on, resume, lock held
package dlc_pkg;
	// variant selection
	localparam logic [1:0] VAR_STANDARD = 2'h0;
	localparam logic [1:0] VAR_HIGH_FREQ = 2'h1;
	localparam logic [1:0] VAR_SIMPLE = 2'h2;

	// divide ratio option codes; code 0 is the default ratio of two
	localparam logic [2:0] DIV_2 = 3'h0;
	localparam logic [2:0] DIV_1P5 = 3'h1;
	localparam logic [2:0] DIV_2P5 = 3'h2;
	localparam logic [2:0] DIV_3 = 3'h3;
	localparam logic [2:0] DIV_4 = 3'h4;
	localparam logic [2:0] DIV_5 = 3'h5;
	localparam logic [2:0] DIV_8 = 3'h6;
	localparam logic [2:0] DIV_16 = 3'h7;

	// timing counts in sys_clk cycles or source periods
	localparam int LOCK_CYCLES_DEFAULT = 5000;
	localparam logic [15:0] DRIFT_CYCLES = 16'h0001;
	localparam logic [2:0] STOP_PERIODS = 3'h2;
	localparam logic [2:0] RESUME_PERIODS = 3'h2;
	localparam logic [2:0] RST_PULSE_CYCLES = 3'h4;

	// controller registers (word aligned byte offsets)
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam int CTRL_RST_BIT = 0;
	localparam int CTRL_DIV_LSB = 1;
	localparam int CTRL_DUTY_BIT = 4;
	localparam int CTRL_WAIT_BIT = 5;
	localparam int CTRL_FBSEL_BIT = 6;
	localparam int CTRL_REQ_BIT = 7;
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_RST_BIT = 2;
	localparam logic [2:0] DIV_RESET = DIV_2;
	localparam logic DUTY_RESET = 1'b1;
	localparam logic WAIT_RESET = 1'b0;
	localparam logic FBSEL_RESET = 1'b0;

	// lock state machine, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_MEASURE = 4'b0010,
		ST_SETTLE = 4'b0100,
		ST_LOCKED = 4'b1000
	} dlc_lock_state_t;

	// divide ratio in half units of the source period
	function automatic logic [5:0] dlc_div_halves(input logic [2:0] code);
		logic [5:0] h;
		h = 6'h04;
		case (code)
			DIV_1P5: h = 6'h03;
			DIV_2P5: h = 6'h05;
			DIV_3: h = 6'h06;
			DIV_4: h = 6'h08;
			DIV_5: h = 6'h0a;
			DIV_8: h = 6'h10;
			DIV_16: h = 6'h20;
			default: h = 6'h04;
		endcase
		return h;
	endfunction
endpackage

// file: dlc_if.sv
// interface joining the clock manager and its controlling logic
`timescale 1ns/1ps
interface dlc_if;
	logic source_clk_in;
	logic feedback_clk_in;
	logic dll_rst;
	logic [2:0] divide_ratio_option;
	logic duty_correct_en;
	logic startup_wait_en;
	logic config_request;
	logic out_phase_0;
	logic out_phase_90;
	logic out_phase_180;
	logic out_phase_270;
	logic doubled_clk_out;
	logic divided_clk_out;
	logic locked;
	logic config_done;

	modport dev (
		input source_clk_in, feedback_clk_in, dll_rst, divide_ratio_option,
		input duty_correct_en, startup_wait_en, config_request,
		output out_phase_0, out_phase_90, out_phase_180, out_phase_270,
		output doubled_clk_out, divided_clk_out, locked, config_done
	);
	modport ctl (
		output source_clk_in, feedback_clk_in, dll_rst, divide_ratio_option,
		output duty_correct_en, startup_wait_en, config_request,
		input out_phase_0, out_phase_90, out_phase_180, out_phase_270,
		input doubled_clk_out, divided_clk_out, locked, config_done
	);
endinterface

// file: dlc_phase_gen.sv
// one phase-shifted 1x output level from the shared timebase
`timescale 1ns/1ps
module dlc_phase_gen #(
	parameter int QUARTER = 0
) (
	input wire logic [15:0] cnt,
	input wire logic [15:0] period,
	input wire logic [15:0] high_time,
	input wire logic duty_en,
	output logic level
);
	import dlc_pkg::*;
	logic [17:0] shift_w;
	logic [15:0] shift;
	logic [15:0] pos;
	logic [15:0] width;

	// shift is QUARTER quarters of the period; width picks corrected or source duty
	always_comb begin
		shift_w = (18'(period) * 18'(QUARTER)) >> 2;
		shift = shift_w[15:0];
		pos = (cnt >= shift) ? (cnt - shift) : (cnt + period - shift);
		width = duty_en ? (period >> 1) : high_time;
		level = (pos < width);
	end
endmodule

// file: dlc_device.sv
// behavioural delay-locked clock manager on the sys_clk sampling grid
`timescale 1ns/1ps
module dlc_device #(
	parameter logic [1:0] VARIANT = dlc_pkg::VAR_STANDARD,
	parameter int LOCK_CYCLES = dlc_pkg::LOCK_CYCLES_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	dlc_if.dev link
);
	import dlc_pkg::*;

	typedef struct packed {
		dlc_lock_state_t st;
		logic src_m;
		logic src_s;
		logic src_p;
		logic fb_m;
		logic fb_s;
		logic fb_p;
		logic fb_seen;
		logic [15:0] per_cnt;
		logic [15:0] hi_cnt;
		logic [15:0] period;
		logic [15:0] high;
		logic [15:0] phase_cnt;
		logic [15:0] lock_cnt;
		logic [19:0] div_cnt;
		logic [2:0] missed;
		logic [2:0] refill;
		logic run;
		logic locked;
		logic done;
		logic div_out;
		logic dbl_out;
		logic [3:0] ph_out;
	} dlc_dev_state_t;

	dlc_dev_state_t q;
	dlc_dev_state_t d;
	logic [3:0] ph_level;
	logic src_rise;
	logic fb_rise;
	logic [15:0] new_period;
	logic [15:0] diff;
	logic [15:0] half;
	logic [15:0] c2;
	logic [21:0] div_prod;
	logic [19:0] div_half;

	// one generator per quarter phase, all sharing the timebase
	for (genvar k = 0; k < 4; k++) begin : g_phase
		dlc_phase_gen #(.QUARTER(k)) u_gen (
			.cnt(q.phase_cnt),
			.period(q.period),
			.high_time(q.high),
			.duty_en(link.duty_correct_en),
			.level(ph_level[k])
		);
	end

	// next-state logic for the whole block
	always_comb begin
		d = q;
		// clock pins from outside pass two flops before anything looks at them
		d.src_m = link.source_clk_in;
		d.src_s = q.src_m;
		d.src_p = q.src_s;
		d.fb_m = link.feedback_clk_in;
		d.fb_s = q.fb_m;
		d.fb_p = q.fb_s;
		src_rise = q.src_s & ~q.src_p;
		fb_rise = q.fb_s & ~q.fb_p;
		new_period = q.per_cnt + 16'h0001;
		diff = (new_period >= q.period) ? (new_period - q.period) : (q.period - new_period);
		half = q.period >> 1;
		c2 = (q.phase_cnt >= half) ? (q.phase_cnt - half) : q.phase_cnt;
		div_prod = (22'(dlc_div_halves(link.divide_ratio_option)) * 22'(q.period)) >> 2;
		div_half = div_prod[19:0];

		// period and high-time measurement of the sampled source
		if (fb_rise) begin
			d.fb_seen = 1'b1;
		end
		if (src_rise) begin
			d.per_cnt = 16'h0000;
			d.hi_cnt = 16'h0001;
		end else begin
			if (q.per_cnt != 16'hffff) begin
				d.per_cnt = new_period;
			end
			if (q.src_s && q.hi_cnt != 16'hffff) begin
				d.hi_cnt = q.hi_cnt + 16'h0001;
			end
		end

		// output timebase free-runs so outputs drain after the source stops
		if (src_rise) begin
			d.phase_cnt = 16'h0000;
			d.missed = 3'h0;
			if (!q.run && q.st != ST_IDLE && q.st != ST_MEASURE) begin
				d.refill = q.refill + 3'h1;
				if (q.refill + 3'h1 >= RESUME_PERIODS) begin
					d.run = 1'b1;
					d.refill = 3'h0;
				end
			end
		end else if (q.phase_cnt + 16'h0001 >= q.period) begin
			d.phase_cnt = 16'h0000;
			if (q.missed != 3'h7) begin
				d.missed = q.missed + 3'h1;
			end
			if (q.missed + 3'h1 >= STOP_PERIODS) begin
				d.run = 1'b0;
			end
		end else begin
			d.phase_cnt = q.phase_cnt + 16'h0001;
		end

		// lock sequencing; a stopped source stalls it without losing lock
		case (q.st)
			ST_IDLE: begin
				if (src_rise) begin
					d.st = ST_MEASURE;
				end
			end
			ST_MEASURE: begin
				if (src_rise) begin
					d.period = new_period;
					d.high = q.hi_cnt;
					if (diff <= DRIFT_CYCLES) begin
						d.st = ST_SETTLE;
						d.lock_cnt = 16'h0000;
						d.run = 1'b1;
					end
				end
			end
			ST_SETTLE: begin
				if (src_rise) begin
					// a feedback edge on the boundary counts for the next period, so the set wins
					d.fb_seen = fb_rise;
					if (diff > DRIFT_CYCLES) begin
						d.st = ST_MEASURE;
					end else if (q.fb_seen) begin
						d.lock_cnt = q.lock_cnt + 16'h0001;
						d.high = q.hi_cnt;
						if (q.lock_cnt == 16'(LOCK_CYCLES - 1)) begin
							d.st = ST_LOCKED;
							d.locked = 1'b1;
						end
					end
				end
			end
			ST_LOCKED: begin
				// drift after lock is not tracked; the controller must reset
				d.locked = 1'b1;
			end
			default: d.st = ST_IDLE;
		endcase

		// divided output toggles every half of N source periods
		if (q.run && q.st != ST_IDLE) begin
			if (q.div_cnt + 20'h00001 >= div_half) begin
				d.div_cnt = 20'h00000;
				d.div_out = ~q.div_out;
			end else begin
				d.div_cnt = q.div_cnt + 20'h00001;
			end
		end

		// registered output levels; quiet while the delay line is empty
		if (q.run) begin
			d.ph_out = ph_level;
			if (q.locked) begin
				d.dbl_out = (c2 < (q.period >> 2));
			end else begin
				d.dbl_out = (q.phase_cnt < (q.period >> 2));
			end
		end else begin
			d.ph_out = 4'h0;
			d.dbl_out = 1'b0;
		end

		// startup wait holds completion until lock
		d.done = link.config_request && (!link.startup_wait_en || d.locked);

		// lock-loop reset zeroes taps and drops lock on the next edge
		if (link.dll_rst) begin
			d.st = ST_IDLE;
			d.locked = 1'b0;
			d.lock_cnt = 16'h0000;
			d.period = 16'h0000;
			d.high = 16'h0000;
			d.phase_cnt = 16'h0000;
			d.div_cnt = 20'h00000;
			d.missed = 3'h0;
			d.refill = 3'h0;
			d.run = 1'b0;
			d.fb_seen = 1'b0;
			d.div_out = 1'b0;
			d.dbl_out = 1'b0;
			d.ph_out = 4'h0;
			d.done = link.config_request && !link.startup_wait_en;
		end
	end

	// single state register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q <= '{st: ST_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

	// variant masking: outputs a variant lacks stay low
	always_comb begin
		link.out_phase_0 = q.ph_out[0];
		link.out_phase_180 = (VARIANT == VAR_SIMPLE) ? 1'b0 : q.ph_out[2];
		link.out_phase_90 = (VARIANT == VAR_STANDARD) ? q.ph_out[1] : 1'b0;
		link.out_phase_270 = (VARIANT == VAR_STANDARD) ? q.ph_out[3] : 1'b0;
		link.doubled_clk_out = (VARIANT == VAR_STANDARD) ? q.dbl_out : 1'b0;
		link.divided_clk_out = (VARIANT == VAR_SIMPLE) ? 1'b0 : q.div_out;
		link.locked = (VARIANT == VAR_SIMPLE) ? 1'b0 : q.locked;
		link.config_done = q.done;
	end
endmodule

// file: dlc_host.sv
// controlling end: AHB-Lite register slave steering the clock manager
`timescale 1ns/1ps
module dlc_host (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic src_clk_pin,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	dlc_if.ctl link
);
	import dlc_pkg::*;

	typedef struct packed {
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] rdata;
		logic [2:0] div_sel;
		logic duty_en;
		logic wait_en;
		logic fb_sel;
		logic req;
		logic [2:0] rst_cnt;
		logic dll_rst;
		logic fb;
	} dlc_host_state_t;

	dlc_host_state_t q;
	dlc_host_state_t d;
	logic addr_take;
	logic [31:0] status_w;
	logic [31:0] ctrl_w;

	// register images and next state
	always_comb begin
		d = q;
		addr_take = hsel && htrans[1] && hready && (hsize == 3'h2);
		ctrl_w = 32'h00000000;
		ctrl_w[CTRL_RST_BIT] = q.dll_rst;
		ctrl_w[CTRL_DIV_LSB +: 3] = q.div_sel;
		ctrl_w[CTRL_DUTY_BIT] = q.duty_en;
		ctrl_w[CTRL_WAIT_BIT] = q.wait_en;
		ctrl_w[CTRL_FBSEL_BIT] = q.fb_sel;
		ctrl_w[CTRL_REQ_BIT] = q.req;
		status_w = 32'h00000000;
		status_w[STAT_LOCK_BIT] = link.locked;
		status_w[STAT_DONE_BIT] = link.config_done;
		status_w[STAT_RST_BIT] = q.dll_rst;

		// reset is a counted pulse, otherwise held low
		if (q.rst_cnt != 3'h0) begin
			d.rst_cnt = q.rst_cnt - 3'h1;
		end

		// data phase of a captured write
		if (q.a_wr) begin
			if (q.a_addr == CTRL_OFF) begin
				d.div_sel = hwdata[CTRL_DIV_LSB +: 3];
				d.duty_en = hwdata[CTRL_DUTY_BIT];
				d.wait_en = hwdata[CTRL_WAIT_BIT];
				d.fb_sel = hwdata[CTRL_FBSEL_BIT];
				d.req = hwdata[CTRL_REQ_BIT];
				if (hwdata[CTRL_RST_BIT]) begin
					d.rst_cnt = RST_PULSE_CYCLES;
				end
			end
		end
		d.dll_rst = (d.rst_cnt != 3'h0);

		// address phase; read data is ready for the following data phase
		d.a_wr = addr_take && hwrite;
		d.a_addr = haddr[7:0];
		if (addr_take && !hwrite) begin
			if (haddr[7:0] == CTRL_OFF) begin
				d.rdata = ctrl_w;
			end else if (haddr[7:0] == STATUS_OFF) begin
				d.rdata = status_w;
			end else begin
				d.rdata = 32'h00000000;
			end
		end

		// feedback only from the phase-0 or doubled output
		d.fb = q.fb_sel ? link.doubled_clk_out : link.out_phase_0;
	end

	// single state register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q <= '{div_sel: DIV_RESET, duty_en: DUTY_RESET, wait_en: WAIT_RESET,
				fb_sel: FBSEL_RESET, default: '0};
		end else begin
			q <= d;
		end
	end

	// bus answers and link drive
	always_comb begin
		hreadyout = 1'b1;
		hresp = 1'b0;
		hrdata = q.rdata;
		link.source_clk_in = src_clk_pin;
		link.feedback_clk_in = q.fb;
		link.dll_rst = q.dll_rst;
		link.divide_ratio_option = q.div_sel;
		link.duty_correct_en = q.duty_en;
		link.startup_wait_en = q.wait_en;
		link.config_request = q.req;
	end
endmodule

// file: dlc_props.sv
// concurrent checks on the link between the clock manager and its controller
`timescale 1ns/1ps
module dlc_props #(
	parameter int LOCK_CYCLES = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic source_clk_in,
	input wire logic feedback_clk_in,
	input wire logic dll_rst,
	input wire logic duty_correct_en,
	input wire logic startup_wait_en,
	input wire logic config_request,
	input wire logic out_phase_0,
	input wire logic out_phase_90,
	input wire logic out_phase_180,
	input wire logic out_phase_270,
	input wire logic doubled_clk_out,
	input wire logic divided_clk_out,
	input wire logic locked,
	input wire logic config_done
);
	logic src_q;
	logic [15:0] edges_q;

	// source rises since the last loop reset; saturates so it never wraps to a small count
	always_ff @(posedge sys_clk) begin
		src_q <= source_clk_in;
		if (sys_rst || dll_rst) begin
			edges_q <= 16'h0000;
		end else if (source_clk_in && !src_q && edges_q != 16'hffff) begin
			edges_q <= edges_q + 16'h0001;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	chk_rst_lock: assert property (dll_rst |=> !locked)
		else $error("lock still shown after loop reset");
	chk_rst_pulse: assert property ($rose(dll_rst) |-> dll_rst [*4] ##1 !dll_rst)
		else $error("loop reset pulse has wrong length");
	chk_rst_quiet: assert property ($rose(dll_rst) |=> !out_phase_0 && !doubled_clk_out && !divided_clk_out)
		else $error("clock outputs not cleared by loop reset");
	chk_lock_count: assert property ($rose(locked) |-> edges_q >= LOCK_CYCLES)
		else $error("lock shown before enough source periods");
	chk_lock_held: assert property (locked && !dll_rst |=> locked)
		else $error("lock dropped without a reset");
	chk_wait_done: assert property (config_done |-> $past(config_request) && (!$past(startup_wait_en) || locked))
		else $error("config done ahead of lock");
	chk_dbl_slow: assert property (!locked && !$past(locked) && doubled_clk_out |-> out_phase_0)
		else $error("unlocked doubled output not a quarter pulse");
	chk_quad_pairs: assert property (locked && $past(locked) && duty_correct_en && $past(duty_correct_en, 2)
		&& (out_phase_0 || out_phase_90 || out_phase_180 || out_phase_270)
		|-> out_phase_180 != out_phase_0 && out_phase_270 != out_phase_90)
		else $error("phase outputs not in quadrature");
	chk_fb_copy: assert property (feedback_clk_in == $past(out_phase_0) || feedback_clk_in == $past(doubled_clk_out))
		else $error("feedback not taken from phase 0 or doubled output");

	cover property ($rose(locked));
	cover property (config_done && startup_wait_en);
	cover property ($rose(divided_clk_out) && locked);
	// outputs drained by a stopped source while lock is held
	cover property (locked && $fell(out_phase_180) && !out_phase_0);
endmodule

// file: tb_top.sv
// self-checking bench for the clock manager and its register controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import dlc_pkg::*;
	localparam int LOCKN = 16;
	localparam int SRC_P = 20;
	localparam int SRC_HI = 6;
	logic sys_clk, sys_rst, src_clk_pin, src_stop, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	int src_cnt = 0;

	dlc_if dlc_if_i();
	dlc_device #(.VARIANT(VAR_STANDARD), .LOCK_CYCLES(LOCKN)) dlc_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.link(dlc_if_i));
	dlc_host dlc_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .src_clk_pin(src_clk_pin), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(dlc_if_i));
	dlc_props #(.LOCK_CYCLES(LOCKN)) dlc_props_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.source_clk_in(dlc_if_i.source_clk_in), .feedback_clk_in(dlc_if_i.feedback_clk_in),
		.dll_rst(dlc_if_i.dll_rst), .duty_correct_en(dlc_if_i.duty_correct_en),
		.startup_wait_en(dlc_if_i.startup_wait_en), .config_request(dlc_if_i.config_request),
		.out_phase_0(dlc_if_i.out_phase_0), .out_phase_90(dlc_if_i.out_phase_90),
		.out_phase_180(dlc_if_i.out_phase_180), .out_phase_270(dlc_if_i.out_phase_270),
		.doubled_clk_out(dlc_if_i.doubled_clk_out), .divided_clk_out(dlc_if_i.divided_clk_out),
		.locked(dlc_if_i.locked), .config_done(dlc_if_i.config_done));

	// 40 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// source clock on the sys_clk grid: 30% high, so duty correction has something to fix
	// a stop request parks it low at a period start, so the restart shows a whole high phase
	always @(posedge sys_clk) begin
		if (src_stop && src_cnt == 0) begin
			src_clk_pin <= 1'b0;
		end else begin
			src_cnt <= (src_cnt == SRC_P - 1) ? 0 : src_cnt + 1;
			src_clk_pin <= (src_cnt < SRC_HI);
		end
	end

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// one single-word transfer; read data lands in rd
	// waits only on hready; the cycle guard is the one limit on a hung slave
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do begin
			@(posedge sys_clk);
		end while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin
			@(posedge sys_clk);
		end while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return dlc_if_i.out_phase_0;
			1: return dlc_if_i.out_phase_90;
			2: return dlc_if_i.out_phase_180;
			3: return dlc_if_i.out_phase_270;
			4: return dlc_if_i.doubled_clk_out;
			default: return dlc_if_i.divided_clk_out;
		endcase
	endfunction

	// high and low run lengths of one output, ending on its next rise
	task automatic meas(input int s, output int hi, output int lo);
		int n;
		n = 0;
		hi = 0;
		lo = 0;
		while (pick(s) !== 1'b0 && n < 400) begin @(posedge sys_clk); n++; end
		while (pick(s) !== 1'b1 && n < 800) begin @(posedge sys_clk); n++; end
		while (pick(s) === 1'b1 && hi < 400) begin @(posedge sys_clk); hi++; end
		while (pick(s) === 1'b0 && lo < 400) begin @(posedge sys_clk); lo++; end
	endtask

	task automatic wait_lock();
		int n;
		n = 0;
		while (dlc_if_i.locked !== 1'b1 && n < 3000) begin @(posedge sys_clk); n++; end
		`CHK(dlc_if_i.locked, 1'b1)
	endtask

	task automatic t_reg_reset();
		ahb(1'b0, 32'h00000000, 32'h00000000);
		`CHK(rd, 32'h00000010)
		ahb(1'b0, 32'h00000004, 32'h00000000);
		`CHK(rd[2:0], 3'h0)
		// unmapped word: write ignored, reads zero
		ahb(1'b1, 32'h00000008, 32'hffffffff);
		ahb(1'b0, 32'h00000008, 32'h00000000);
		`CHK(rd, 32'h00000000)
		ahb(1'b0, 32'h00000000, 32'h00000000);
		`CHK(rd, 32'h00000010)
	endtask

	task automatic t_lock();
		int hi, lo, d, s;
		ahb(1'b1, 32'h00000000, 32'h00000091);
		ahb(1'b0, 32'h00000004, 32'h00000000);
		`CHK(rd[2], 1'b1)
		`CHK(dlc_if_i.locked, 1'b0)
		meas(4, hi, lo);
		meas(4, hi, lo);
		`CHK(hi, 5)
		`CHK(lo, 15)
		wait_lock();
		ahb(1'b0, 32'h00000004, 32'h00000000);
		`CHK(rd[1:0], 2'h3)
		meas(4, hi, lo);
		meas(4, hi, lo);
		`CHK(hi + lo, SRC_P / 2)
		`CHK(hi, lo)
		meas(0, hi, lo);
		`CHK(hi, SRC_P / 2)
		`CHK(lo, SRC_P / 2)
		// quarter-period offsets from the rise of phase 0
		for (s = 1; s < 4; s++) begin
			meas(0, hi, lo);
			d = 0;
			while (pick(s) === 1'b1 && d < 40) begin @(posedge sys_clk); d++; end
			while (pick(s) !== 1'b1 && d < 40) begin @(posedge sys_clk); d++; end
			`CHK(d, s * SRC_P / 4)
		end
	endtask

	task automatic t_divide();
		int halves[8] = '{4, 3, 5, 6, 8, 10, 16, 32};
		int hi, lo;
		for (int c = 0; c < 8; c++) begin
			ahb(1'b1, 32'h00000000, 32'h00000090 | (32'(c) << 1));
			meas(5, hi, lo);
			meas(5, hi, lo);
			`CHK(hi, halves[c] * SRC_P / 4)
			`CHK(lo, halves[c] * SRC_P / 4)
		end
	endtask

	// source stopped in a low phase: outputs drain and go quiet, lock holds, restart refills
	task automatic t_stop();
		int n;
		n = 0;
		src_stop <= 1'b1;
		repeat (3 * SRC_P) @(posedge sys_clk);
		repeat (SRC_P) begin
			@(posedge sys_clk);
			if (dlc_if_i.out_phase_0 !== 1'b0 || dlc_if_i.out_phase_180 !== 1'b0) begin
				n++;
			end
		end
		`CHK(n, 0)
		`CHK(dlc_if_i.locked, 1'b1)
		src_stop <= 1'b0;
		n = 0;
		while (dlc_if_i.out_phase_0 !== 1'b1 && n < 4 * SRC_P) begin
			@(posedge sys_clk);
			n++;
		end
		// phase 0 returns on the second source rise after restart, not the first
		`CHK(n > SRC_P && n <= 2 * SRC_P, 1'b1)
		`CHK(dlc_if_i.locked, 1'b1)
	endtask

	task automatic t_duty_off();
		int hi, lo;
		ahb(1'b1, 32'h00000000, 32'h00000080);
		meas(0, hi, lo);
		meas(0, hi, lo);
		`CHK(hi, SRC_HI)
		`CHK(lo, SRC_P - SRC_HI)
	endtask

	task automatic t_wait();
		ahb(1'b1, 32'h00000000, 32'h000000f1); // doubled output as feedback
		// lock must be gone within four source periods
		repeat (4 * SRC_P) @(posedge sys_clk);
		ahb(1'b0, 32'h00000004, 32'h00000000);
		`CHK(rd[1:0], 2'h0)
		wait_lock();
		ahb(1'b0, 32'h00000004, 32'h00000000);
		`CHK(rd[1:0], 2'h3)
	endtask

	initial begin
		sys_rst = 1'b1;
		src_stop = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h00000000;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		t_reg_reset();
		t_lock();
		t_divide();
		t_stop();
		t_duty_off();
		t_wait();
		complete_run();
	end
endmodule
